// ### rtl/rt_pin1_pkg.sv
// Purpose: Constants and types for the real-time pin 1 signal selector.
// Assumes: One clock, the line-locked clock, and a subaddressed register port.
// Notes: Subaddresses are the documented register numbers.
//
// What this block does
// RQ1 - Select field 12h[7:4] picks the pin signal.
// RQ2 - Bit 11h[6] inverts the routed signal.
// RQ3 - Codes 0,1,2: tri-state, low, pixel qualifier.
// RQ4 - Code 3 gives the half-rate qualifier.
// RQ5 - Code 4 gives the horizontal lock flag.
// RQ6 - Bit 13h[3] picks standard or fast lock.
// RQ7 - Software avoids fast lock on unstable sources.
// RQ8 - Code 5 gives vertical and horizontal lock.
// RQ9 - Code 6 adds colour detected to lock.
// RQ10 - Code 8 gives reference over 720 pixels.
// RQ11 - Reference rises at each active line start.
// RQ12 - Reference continues through vertical blanking.
// RQ13 - Code 9 sync, 06h/07h in eight-clock steps.
// RQ14 - Sync fine delay 11h[5:4] in two-clock steps.
// RQ15 - Code 10 gives reference ANDed with gate.
// RQ16 - Code 12 gives vertical sync.
// RQ17 - Code 13 gives window gate, 9-bit lines.
// RQ18 - Code 15 gives field identifier at start.
// RQ19 - Reserved codes are unused, shown as tri-state.
// RQ20 - Select or polarity changes reach pin promptly.
package rt_pin1_pkg;

  // Register subaddresses.
  localparam logic [7:0] SA_HSYNC_BEGIN = 8'h06;
  localparam logic [7:0] SA_HSYNC_STOP = 8'h07;
  localparam logic [7:0] SA_POLARITY = 8'h11;
  localparam logic [7:0] SA_PIN_SELECT = 8'h12;
  localparam logic [7:0] SA_OUTPUT_CTRL = 8'h13;
  localparam logic [7:0] SA_WIN_START = 8'h15;
  localparam logic [7:0] SA_WIN_STOP = 8'h16;
  localparam logic [7:0] SA_WIN_MSB = 8'h17;

  // Field positions.
  localparam int SEL_LSB = 4;
  localparam int INVERT_BIT = 6;
  localparam int FINE_DELAY_LSB = 4;
  localparam int LOCK_CHOICE_BIT = 3;
  localparam int START_MSB_BIT = 0;
  localparam int STOP_MSB_BIT = 1;
  localparam int FIELD_SHIFT_BIT = 2;

  // Reset values of all registers.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Timing counts in line-locked clocks, pixels and lines.
  localparam int LINE_CLOCKS = 1728;
  localparam int HREF_PIXELS = 720;
  localparam int CLOCKS_PER_PIXEL = 2;
  localparam int HREF_START = 288;
  localparam int FIELD_LINES = 312;
  localparam int VSYNC_LINES = 3;
  localparam int COARSE_STEP_SHIFT = 3;
  localparam int FINE_STEP_SHIFT = 1;

  // Select codes for the pin.
  typedef enum logic [3:0] {
    SEL_TRISTATE = 4'b0000,
    SEL_LOW = 4'b0001,
    SEL_PIXEL_Q = 4'b0010,
    SEL_HALF_Q = 4'b0011,
    SEL_HLOCK = 4'b0100,
    SEL_VHLOCK = 4'b0101,
    SEL_LOCK_COLOUR = 4'b0110,
    SEL_HREF = 4'b1000,
    SEL_HSYNC = 4'b1001,
    SEL_GATED_REF = 4'b1010,
    SEL_VSYNC = 4'b1100,
    SEL_VERTICAL_WINDOW_GATE = 4'b1101,
    SEL_FIELD_ID = 4'b1111
  } pin1_sel_t;

endpackage : rt_pin1_pkg

// ### rtl/rt_timing_if.sv
// Purpose: Carries timing settings and timing signals between modules.
// Assumes: Both ends run on the same clock.
// Notes: The selector owns the settings, the generator owns the signals.
`timescale 1ns/1ps
`default_nettype none
interface rt_timing_if;
  logic [7:0] hsync_begin_value;
  logic [7:0] hsync_stop_value;
  logic [1:0] hsync_fine_delay;
  logic [8:0] window_start_line;
  logic [8:0] window_stop_line;
  logic window_field_shift;
  logic pixel_rate_qualifier;
  logic half_rate_qualifier;
  logic horiz_reference;
  logic horiz_sync_pulse;
  logic vertical_sync_pulse;
  logic vertical_window_gate;
  logic field_identifier;

  modport gen (
    input hsync_begin_value, hsync_stop_value, hsync_fine_delay,
    input window_start_line, window_stop_line, window_field_shift,
    output pixel_rate_qualifier, half_rate_qualifier, horiz_reference,
    output horiz_sync_pulse, vertical_sync_pulse, vertical_window_gate,
    output field_identifier
  );

  modport sel (
    output hsync_begin_value, hsync_stop_value, hsync_fine_delay,
    output window_start_line, window_stop_line, window_field_shift,
    input pixel_rate_qualifier, half_rate_qualifier, horiz_reference,
    input horiz_sync_pulse, vertical_sync_pulse, vertical_window_gate,
    input field_identifier
  );
endinterface : rt_timing_if
`default_nettype wire

// ### rtl/rt_timing_gen.sv
// Purpose: Line and field timing for the real-time pin sources.
// Assumes: The clock is the line-locked clock; two clocks make one pixel.
// Notes: Line and field lengths are parameters with plain defaults.
`timescale 1ns/1ps
`default_nettype none
module rt_timing_gen
  import rt_pin1_pkg::*;
#(
  parameter int LINE_LEN = LINE_CLOCKS,
  parameter int FIELD_LEN = FIELD_LINES
) (
  input wire logic clock,
  input wire logic rst_n,
  rt_timing_if.gen tim
);

  logic [10:0] hcnt_r, hcnt_nxt;
  logic [8:0] vline_r, vline_nxt;
  logic [1:0] div_r, div_nxt;
  logic href_r, href_nxt;
  logic hs_r, hs_nxt;
  logic vs_r, vs_nxt;
  logic gate_r, gate_nxt;
  logic fid_r, fid_nxt;
  logic [11:0] hs_begin, hs_end, fine;
  logic [8:0] gate_start, gate_stop;

  localparam logic [10:0] LAST_CLOCK = 11'(LINE_LEN - 1);
  localparam logic [8:0] LAST_LINE = 9'(FIELD_LEN - 1);
  localparam logic [10:0] HREF_ON = 11'(HREF_START);
  localparam logic [10:0] HREF_OFF =
    11'(HREF_START + HREF_PIXELS * CLOCKS_PER_PIXEL);
  localparam logic [8:0] VS_END = 9'(VSYNC_LINES);

  // Sync positions from coarse and fine settings, and the shifted gate.
  always_comb begin
    fine = 12'({tim.hsync_fine_delay, 1'b0}); // RQ14
    hs_begin = 12'({tim.hsync_begin_value, 3'b000}) + fine; // RQ13
    hs_end = 12'({tim.hsync_stop_value, 3'b000}) + fine; // RQ13
    gate_start = tim.window_start_line;
    gate_stop = tim.window_stop_line;
    // The next field value keeps the gate free of a glitch at the toggle.
    if (tim.window_field_shift && fid_nxt) begin
      gate_start = tim.window_start_line + 9'h001; // RQ17
      gate_stop = tim.window_stop_line + 9'h001;
    end
  end

  // Next state of counters and every timing signal.
  always_comb begin
    div_nxt = div_r + 2'h1;
    hcnt_nxt = (hcnt_r == LAST_CLOCK) ? 11'h000 : hcnt_r + 11'h001;
    vline_nxt = vline_r;
    fid_nxt = fid_r;
    if (hcnt_r == LAST_CLOCK) begin
      vline_nxt = (vline_r == LAST_LINE) ? 9'h000 : vline_r + 9'h001;
      if (vline_nxt == tim.window_start_line) begin
        fid_nxt = ~fid_r; // RQ18
      end
    end
    // Reference runs on every line, blanking lines included.
    href_nxt = (hcnt_nxt >= HREF_ON) && (hcnt_nxt < HREF_OFF); // RQ10 RQ11 RQ12
    hs_nxt = ({1'b0, hcnt_nxt} >= hs_begin) && ({1'b0, hcnt_nxt} < hs_end);
    vs_nxt = vline_nxt < VS_END; // RQ16
    gate_nxt = (vline_nxt >= gate_start) && (vline_nxt < gate_stop); // RQ17
  end

  // Timing registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_r <= 11'h000;
      vline_r <= 9'h000;
      div_r <= 2'h0;
      href_r <= 1'b0;
      hs_r <= 1'b0;
      vs_r <= 1'b1;
      gate_r <= 1'b0;
      fid_r <= 1'b0;
    end else begin
      hcnt_r <= hcnt_nxt;
      vline_r <= vline_nxt;
      div_r <= div_nxt;
      href_r <= href_nxt;
      hs_r <= hs_nxt;
      vs_r <= vs_nxt;
      gate_r <= gate_nxt;
      fid_r <= fid_nxt;
    end
  end

  // The qualifiers are the two divider stages.
  assign tim.pixel_rate_qualifier = div_r[0]; // RQ3
  assign tim.half_rate_qualifier = div_r[1]; // RQ4
  assign tim.horiz_reference = href_r;
  assign tim.horiz_sync_pulse = hs_r;
  assign tim.vertical_sync_pulse = vs_r;
  assign tim.vertical_window_gate = gate_r;
  assign tim.field_identifier = fid_r;

endmodule : rt_timing_gen
`default_nettype wire

// ### rtl/rt_pin1_signal_select.sv
// Purpose: Register set and output selector for real-time pin 1.
// Assumes: Register writes and lock inputs are on the clock's domain.
// Notes: The pin is split into a level and an output enable.
`timescale 1ns/1ps
`default_nettype none
module rt_pin1_signal_select
  import rt_pin1_pkg::*;
#(
  parameter int LINE_LEN = LINE_CLOCKS,
  parameter int FIELD_LEN = FIELD_LINES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic hlock_standard,
  input wire logic hlock_fast,
  input wire logic vlock,
  input wire logic colour_detected,
  output logic rt_pin1_output,
  output logic rt_pin1_oe
);

  logic [7:0] hsb_r, hsb_nxt;
  logic [7:0] hss_r, hss_nxt;
  logic [7:0] pol_r, pol_nxt;
  logic [7:0] rt_pin_signal_select_r, rt_pin_signal_select_nxt;
  logic [7:0] outctl_r, outctl_nxt;
  logic [7:0] window_start_line_r, window_start_line_nxt;
  logic [7:0] window_stop_line_r, window_stop_line_nxt;
  logic [7:0] vmsb_r, vmsb_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic horiz_lock_flag;
  logic vert_horiz_lock_flag;
  logic lock_and_colour_flag;
  logic gated_line_reference;
  logic rt_pin1_invert;
  logic lock_indicator_choice;
  logic chosen;
  pin1_sel_t sel;

  rt_timing_if tim ();

  rt_timing_gen #(
    .LINE_LEN(LINE_LEN),
    .FIELD_LEN(FIELD_LEN)
  ) u_timing (
    .clock(clock),
    .rst_n(rst_n),
    .tim(tim)
  );

  // Returns the value of a register selected by its subaddress.
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      SA_HSYNC_BEGIN: val = hsb_r;
      SA_HSYNC_STOP: val = hss_r;
      SA_POLARITY: val = pol_r;
      SA_PIN_SELECT: val = rt_pin_signal_select_r;
      SA_OUTPUT_CTRL: val = outctl_r;
      SA_WIN_START: val = window_start_line_r;
      SA_WIN_STOP: val = window_stop_line_r;
      SA_WIN_MSB: val = vmsb_r;
      default: val = 8'h00;
    endcase
    return val;
  endfunction : read_mux

  // Register writes by subaddress; read data follows the address.
  always_comb begin
    hsb_nxt = hsb_r;
    hss_nxt = hss_r;
    pol_nxt = pol_r;
    rt_pin_signal_select_nxt = rt_pin_signal_select_r;
    outctl_nxt = outctl_r;
    window_start_line_nxt = window_start_line_r;
    window_stop_line_nxt = window_stop_line_r;
    vmsb_nxt = vmsb_r;
    if (reg_wr) begin
      unique case (reg_addr)
        SA_HSYNC_BEGIN: hsb_nxt = reg_wdata;
        SA_HSYNC_STOP: hss_nxt = reg_wdata;
        SA_POLARITY: pol_nxt = reg_wdata;
        SA_PIN_SELECT: rt_pin_signal_select_nxt = reg_wdata;
        SA_OUTPUT_CTRL: outctl_nxt = reg_wdata;
        SA_WIN_START: window_start_line_nxt = reg_wdata;
        SA_WIN_STOP: window_stop_line_nxt = reg_wdata;
        SA_WIN_MSB: vmsb_nxt = reg_wdata;
        default: ;
      endcase
    end
    rdata_nxt = read_mux(reg_addr);
  end

  // Register file.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hsb_r <= REG_RESET;
      hss_r <= REG_RESET;
      pol_r <= REG_RESET;
      rt_pin_signal_select_r <= REG_RESET;
      outctl_r <= REG_RESET;
      window_start_line_r <= REG_RESET;
      window_stop_line_r <= REG_RESET;
      vmsb_r <= REG_RESET;
      rdata_r <= REG_RESET;
    end else begin
      hsb_r <= hsb_nxt;
      hss_r <= hss_nxt;
      pol_r <= pol_nxt;
      rt_pin_signal_select_r <= rt_pin_signal_select_nxt;
      outctl_r <= outctl_nxt;
      window_start_line_r <= window_start_line_nxt;
      window_stop_line_r <= window_stop_line_nxt;
      vmsb_r <= vmsb_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Settings handed to the timing generator.
  assign tim.hsync_begin_value = hsb_r; // RQ13
  assign tim.hsync_stop_value = hss_r; // RQ13
  assign tim.hsync_fine_delay = pol_r[FINE_DELAY_LSB +: 2]; // RQ14
  assign tim.window_start_line = {vmsb_r[START_MSB_BIT], window_start_line_r}; // RQ17 RQ18
  assign tim.window_stop_line = {vmsb_r[STOP_MSB_BIT], window_stop_line_r}; // RQ17
  assign tim.window_field_shift = vmsb_r[FIELD_SHIFT_BIT]; // RQ17

  // Decoded control bits and the lock and gate combinations.
  assign sel = pin1_sel_t'(rt_pin_signal_select_r[SEL_LSB +: 4]); // RQ1
  assign rt_pin1_invert = pol_r[INVERT_BIT]; // RQ2
  assign lock_indicator_choice = outctl_r[LOCK_CHOICE_BIT];
  // Fast lock is unsafe for unstable time bases; software decides.
  assign horiz_lock_flag = lock_indicator_choice ? hlock_fast
                                                 : hlock_standard; // RQ6 RQ7
  assign vert_horiz_lock_flag = vlock & hlock_standard; // RQ8
  assign lock_and_colour_flag = vert_horiz_lock_flag & colour_detected; // RQ9
  assign gated_line_reference = tim.horiz_reference
                                & tim.vertical_window_gate; // RQ15

  // Output selection; reserved codes leave the pin undriven.
  always_comb begin
    chosen = 1'b0;
    oe_nxt = 1'b1;
    unique case (sel)
      SEL_TRISTATE: oe_nxt = 1'b0; // RQ3
      SEL_LOW: chosen = 1'b0; // RQ3
      SEL_PIXEL_Q: chosen = tim.pixel_rate_qualifier; // RQ3
      SEL_HALF_Q: chosen = tim.half_rate_qualifier; // RQ4
      SEL_HLOCK: chosen = horiz_lock_flag; // RQ5
      SEL_VHLOCK: chosen = vert_horiz_lock_flag; // RQ8
      SEL_LOCK_COLOUR: chosen = lock_and_colour_flag; // RQ9
      SEL_HREF: chosen = tim.horiz_reference; // RQ10
      SEL_HSYNC: chosen = tim.horiz_sync_pulse; // RQ13
      SEL_GATED_REF: chosen = gated_line_reference; // RQ15
      SEL_VSYNC: chosen = tim.vertical_sync_pulse; // RQ16
      SEL_VERTICAL_WINDOW_GATE: chosen = tim.vertical_window_gate; // RQ17
      SEL_FIELD_ID: chosen = tim.field_identifier; // RQ18
      default: oe_nxt = 1'b0; // RQ19
    endcase
    pin_nxt = chosen ^ rt_pin1_invert; // RQ2
  end

  // Pin registers follow the settings every clock, so no trigger is needed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt; // RQ20
      oe_r <= oe_nxt; // RQ20
    end
  end

  assign rt_pin1_output = pin_r;
  assign rt_pin1_oe = oe_r;
  assign reg_rdata = rdata_r;

endmodule : rt_pin1_signal_select
`default_nettype wire

// ### tb/rt_pin1_checker.sv
// Purpose: Port assertions for the pin 1 selector.
// Assumes: Settings are shadowed from the write port.
// Notes: Pin lags the register by one clock.
`timescale 1ns/1ps
`default_nettype none
module rt_pin1_checker
  import rt_pin1_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic hlock_standard,
  input wire logic hlock_fast,
  input wire logic vlock,
  input wire logic colour_detected,
  input wire logic rt_pin1_output,
  input wire logic rt_pin1_oe
);
  logic [3:0] sel_r;
  logic inv_r;
  logic choice_r;
  logic hl;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow copies of select, invert and lock choice.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 4'h0;
      inv_r <= 1'b0;
      choice_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == SA_PIN_SELECT) sel_r <= reg_wdata[7:4];
      if (reg_addr == SA_POLARITY) inv_r <= reg_wdata[6];
      if (reg_addr == SA_OUTPUT_CTRL) choice_r <= reg_wdata[3];
    end
  end
  // Lock flag picked by the choice bit.
  assign hl = choice_r ? hlock_fast : hlock_standard;
  sequence s_hold(logic [3:0] c);
    sel_r == c && $stable(sel_r) && $stable(inv_r) && $stable(choice_r)
      && $stable({hlock_standard, hlock_fast, vlock, colour_detected});
  endsequence
  sequence s_wr_low;
    reg_wr && reg_addr == SA_PIN_SELECT && reg_wdata[7:4] == 4'h1
      ##1 !(reg_wr && reg_addr == SA_PIN_SELECT) [*2];
  endsequence
  property p_tri;
    (sel_r inside {4'h0, 4'h7, 4'hB, 4'hE}) |=> !rt_pin1_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("pin driven");
  property p_low;
    s_hold(4'h1) |=> rt_pin1_oe && rt_pin1_output == $past(inv_r);
  endproperty
  a_low: assert property (p_low) else $error("low wrong");
  property p_pix;
    s_hold(4'h2) [*2] |=> rt_pin1_output != $past(rt_pin1_output);
  endproperty
  a_pix: assert property (p_pix) else $error("no toggle");
  property p_half;
    s_hold(4'h3) [*3] |=> rt_pin1_output != $past(rt_pin1_output, 2);
  endproperty
  a_half: assert property (p_half) else $error("half wrong");
  property p_hl;
    s_hold(4'h4) |=> rt_pin1_output == ($past(hl) ^ $past(inv_r));
  endproperty
  a_hl: assert property (p_hl) else $error("hlock wrong");
  property p_vl;
    s_hold(4'h5) |=> rt_pin1_output
      == ($past(vlock & hlock_standard) ^ $past(inv_r));
  endproperty
  a_vl: assert property (p_vl) else $error("vlock wrong");
  property p_dl;
    s_hold(4'h6) |=> rt_pin1_output
      == ($past(vlock & hlock_standard & colour_detected) ^ $past(inv_r));
  endproperty
  a_dl: assert property (p_dl) else $error("colour wrong");
  property p_prompt;
    s_wr_low |=> rt_pin1_oe;
  endproperty
  a_prompt: assert property (p_prompt) else $error("slow");
endmodule : rt_pin1_checker
bind rt_pin1_signal_select rt_pin1_checker u_chk (.clock, .rst_n,
  .reg_wr, .reg_addr, .reg_wdata, .hlock_standard, .hlock_fast, .vlock,
  .colour_detected, .rt_pin1_output, .rt_pin1_oe);
`default_nettype wire

// ### tb/rt_pin_capture.sv
// Purpose: Capture logic that samples the pin.
// Assumes: Same clock as the selector.
// Notes: Counts high samples and rising edges while driven.
`timescale 1ns/1ps
`default_nettype none
module rt_pin_capture (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic clr,
  output logic pin_level,
  output logic [15:0] n_high,
  output logic [15:0] n_rise
);
  logic last_r;
  // No pull is fitted, so a released pin shows the inverse level.
  assign pin_level = pin_oe ? pin_out : ~last_r;
  // Counters restart on clr.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'b0;
      n_high <= 16'h0;
      n_rise <= 16'h0;
    end else begin
      last_r <= pin_level;
      if (clr) begin
        n_high <= 16'h0;
        n_rise <= 16'h0;
      end else if (pin_oe) begin
        n_high <= n_high + {15'h0, pin_level};
        n_rise <= n_rise + {15'h0, pin_level & ~last_r};
      end
    end
  end
endmodule : rt_pin_capture
`default_nettype wire

// ### tb/tb.sv
// Purpose: Register driven tests of the pin 1 selector.
// Assumes: Full line length and a short field.
// Notes: Pin is sampled through the capture model.
`timescale 1ns/1ps
`default_nettype none
module tb
  import rt_pin1_pkg::*;
;
  localparam int L = LINE_CLOCKS;
  localparam int FL = 8;
  localparam int HW = HREF_PIXELS * CLOCKS_PER_PIXEL;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic hlock_standard = 1'b0;
  logic hlock_fast = 1'b0;
  logic vlock = 1'b0;
  logic colour_detected = 1'b0;
  logic rt_pin1_output;
  logic rt_pin1_oe;
  logic clr = 1'b0;
  logic [15:0] n_high;
  logic [15:0] n_rise;
  logic [7:0] d;
  logic [3:0] v;
  logic e;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #25 clock = ~clock;
  rt_pin1_signal_select #(.LINE_LEN(L), .FIELD_LEN(FL)) dut (.clock,
    .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .hlock_standard,
    .hlock_fast, .vlock, .colour_detected, .rt_pin1_output, .rt_pin1_oe);
  rt_pin_capture cap (.clock, .rst_n, .pin_out(rt_pin1_output),
    .pin_oe(rt_pin1_oe), .clr, .pin_level(), .n_high, .n_rise);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 x = reg_rdata;
  endtask : rd
  task automatic meas(input int n, input int hi, input int ri);
    repeat (3) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (n) @(posedge clock);
    #1 chk(n_high, hi);
    chk(n_rise, ri);
  endtask : meas
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Watchdog.
  initial begin
    repeat (95000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(SA_PIN_SELECT, d);
    chk(d, 8'h00);
    wr(SA_PIN_SELECT, 8'h20);
    wr(8'h55, 8'h20);
    rd(SA_PIN_SELECT, d);
    chk(d, 8'h20);
    rd(8'h55, d);
    chk(d, 8'h00);
    // Every code, reserved ones left undriven by the selector's default branch.
    for (int k = 0; k < 16; k++) begin
      wr(SA_PIN_SELECT, {4'(k), 4'h0});
      repeat (2) @(posedge clock);
      #1 chk(rt_pin1_oe, !(k inside {0, 7, 11, 14}));
      if (k == 1) chk(rt_pin1_output, 1'b0);
    end
    wr(SA_POLARITY, 8'h40);
    rd(SA_POLARITY, d);
    chk(d, 8'h40);
    wr(SA_PIN_SELECT, 8'h10);
    repeat (2) @(posedge clock);
    #1 chk(rt_pin1_output, 1'b1);
    wr(SA_POLARITY, 8'h00);
    // Lock flags; all sixteen combinations of the four lock inputs, the fast flag toggling too.
    for (int c = 0; c < 6; c++) begin
      wr(SA_OUTPUT_CTRL, (c >= 3) ? 8'h08 : 8'h00);
      wr(SA_PIN_SELECT, {4'(4 + c % 3), 4'h0});
      for (int i = 0; i < 16; i++) begin
        v = 4'(i);
        @(posedge clock);
        {hlock_standard, hlock_fast, vlock, colour_detected} <= v;
        repeat (2) @(posedge clock);
        e = (c == 3) ? v[2] : (c % 3 == 0) ? v[3] :
          (c % 3 == 1) ? v[3] & v[1] : v[3] & v[1] & v[0];
        #1 chk(rt_pin1_output, e);
      end
    end
    // Qualifiers: every clock and every second clock.
    wr(SA_PIN_SELECT, 8'h20);
    meas(64, 32, 32);
    wr(SA_PIN_SELECT, 8'h30);
    meas(64, 32, 16);
    wr(SA_HSYNC_BEGIN, 8'h02);
    wr(SA_HSYNC_STOP, 8'h0A);
    wr(SA_POLARITY, 8'h10);
    wr(SA_PIN_SELECT, 8'h90);
    meas(L, 8 << COARSE_STEP_SHIFT, 1);
    wr(SA_POLARITY, 8'h50);
    meas(L, L - (8 << COARSE_STEP_SHIFT), 1);
    wr(SA_POLARITY, 8'h00);
    wr(SA_PIN_SELECT, 8'h80);
    meas(FL * L, FL * HW, FL);
    wr(SA_WIN_START, 8'h02);
    wr(SA_WIN_STOP, 8'h05);
    wr(SA_PIN_SELECT, 8'hA0);
    meas(FL * L, 3 * HW, 3);
    wr(SA_PIN_SELECT, 8'hC0);
    meas(FL * L, VSYNC_LINES * L, 1);
    wr(SA_PIN_SELECT, 8'hD0);
    meas(FL * L, 3 * L, 1);
    // Field identifier toggles once a field, so watch two fields.
    wr(SA_PIN_SELECT, 8'hF0);
    meas(2 * FL * L, FL * L, 1);
    complete_run();
  end
endmodule : tb
`default_nettype wire
